// *** rtl/adcsr_defines.vh ***
// register offsets, field positions and reset values for the adc control block
// assumes inclusion by bare name from the design files
`ifndef ADCSR_DEFINES_VH
`define ADCSR_DEFINES_VH

// -----------------------------------------------------------------
// register-bus offsets
// -----------------------------------------------------------------
`define ADCSR_ADDR_CONFIG 8'hbc
`define ADCSR_ADDR_RES_LOW 8'hbd
`define ADCSR_ADDR_RES_HIGH 8'hbe
`define ADCSR_ADDR_CONTROL 8'he8
`define ADCSR_ADDR_CHANNEL 8'hbb

// -----------------------------------------------------------------
// indirect gain addresses
// -----------------------------------------------------------------
`define ADCSR_GAIN_HIGH 8'h04
`define ADCSR_GAIN_LOW 8'h07
`define ADCSR_GAIN_EXTRA 8'h08

// -----------------------------------------------------------------
// control and config bit positions
// -----------------------------------------------------------------
`define ADCSR_CN_ENABLE 7
`define ADCSR_CN_BURST 6
`define ADCSR_CN_DONE 5
`define ADCSR_CN_BUSY 4
`define ADCSR_CN_WIN 3
`define ADCSR_CN_LJUST 2
`define ADCSR_CF_GAIN_PROGRAM_ENABLE 0

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define ADCSR_RST_CONFIG 8'hf8
`define ADCSR_RST_CONTROL 8'h00
`define ADCSR_RST_RESULT 8'h00
`define ADCSR_RST_GAIN_HIGH 8'h00
`define ADCSR_RST_GAIN_LOW 4'h0
`define ADCSR_RST_GAIN_EXTRA 1'b1
`define ADCSR_RST_CHANNEL 5'h00

// -----------------------------------------------------------------
// start sources
// -----------------------------------------------------------------
`define ADCSR_SRC_WRITE 2'h0
`define ADCSR_SRC_TIMER1 2'h1
`define ADCSR_SRC_PIN 2'h2
`define ADCSR_SRC_TIMER2 2'h3

`endif

// *** rtl/adcsr_clkdiv.v ***
// sar clock divider: one pulse every (divide + 1) source ticks
// assumes source ticks are one-cycle pulses on clk_sys_i
`timescale 1ns/1ps
module adcsr_clkdiv (
	// clock and reset
	input wire clk_sys_i,
	input wire rstn_i,
	// control
	input wire run_i,
	input wire src_tick_i,
	input wire [4:0] divide_i,
	// output
	output reg sar_tick_o
);

reg [4:0] count;

always @(posedge clk_sys_i) begin
	if (!rstn_i || !run_i) begin
		count <= 5'h00;
		sar_tick_o <= 1'b0;
	end else begin
		sar_tick_o <= 1'b0;
		if (src_tick_i) begin
			if (count >= divide_i) begin
				count <= 5'h00;
				sar_tick_o <= 1'b1;
			end else begin
				count <= count + 5'h01;
			end
		end
	end
end

endmodule // adcsr_clkdiv

// *** rtl/adcsr_ctrl.v ***
// adc control registers: config, control, result, channel, indirect gain
// assumes the analog core reports one 12-bit sample per done pulse
`timescale 1ns/1ps
`include "adcsr_defines.vh"

// What this block does
// - gain address 0x04 holds upper eight gain bits
// - gain address 0x07 bits 7-4 hold low gain nibble, resets zero
// - gain address 0x08 bit 0 adds one sixty-fourth, resets one
// - five-bit channel field selects converter positive input
// - channel register upper three bits read zero, writes ignored
// - sar clock is source clock divided by divide field plus one
// - source clock is system clock, or burst oscillator in burst mode
// - repeat field sums 1, 4, 8 or 16 conversions
// - non-burst needs start per conversion; burst one start runs all
// - right justified high byte holds upper accumulated bits
// - right justified low byte holds lowest eight result bits
// - left justified: high byte top eight, low byte nibble then zeros
// - enable bit zero shuts converter down, one makes it active
// - done flag sets when busy falls at the last conversion, not on an abort
// - busy reads one while converting; write one starts in mode 00
// - window flag set on match, cleared only by software
// - start source: busy write, timer one, pin rise, timer two
// - config bit 0 switches data pair to gain programming
// - config resets f8, control and data bytes reset zero
// - gain mode: high byte write addresses, low byte write loads
// - gain registers are write only
// - gain is word over 4096 plus extra sixty-fourth
module adcsr_ctrl (
	// clock and reset
	input wire clk_sys_i,
	input wire rstn_i,
	// special-function-register bus
	input wire [7:0] sfr_addr_i,
	input wire [7:0] sfr_wdata_i,
	input wire sfr_we_i,
	input wire sfr_re_i,
	output reg [7:0] sfr_rdata_o,
	// start sources and burst oscillator
	input wire timer1_ovf_i,
	input wire timer2_ovf_i,
	input wire external_convert_start_pin_i,
	input wire burst_osc_tick_i,
	// analog core
	input wire sample_done_i,
	input wire [11:0] sample_i,
	input wire window_match_i,
	output reg sample_start_o,
	output wire sar_tick_o,
	output reg converter_enable_o,
	output reg [4:0] input_channel_field_o,
	output reg [11:0] gain_word_o,
	output reg extra_sixtyfourth_gain_o,
	output reg [15:0] accum_o
);

// -----------------------------------------------------------------
// registers
// -----------------------------------------------------------------
reg [7:0] converter_config;
reg [7:0] converter_control;
reg [7:0] gain_addr;
reg [15:0] accum;
reg [4:0] done_count;
reg busy;
reg pin_s1;
reg pin_s2;
reg pin_s3;
reg [4:0] next_done_count;

wire [4:0] sar_clock_divide = converter_config[7:3];
wire [1:0] repeat_count_field = converter_config[2:1];
wire gain_program_enable = converter_config[`ADCSR_CF_GAIN_PROGRAM_ENABLE];
wire burst_mode_enable = converter_control[`ADCSR_CN_BURST];
wire left_justify_select = converter_control[`ADCSR_CN_LJUST];
wire [1:0] start_source_select = converter_control[1:0];

wire wr_control = sfr_we_i && sfr_addr_i == `ADCSR_ADDR_CONTROL;
wire wr_high = sfr_we_i && sfr_addr_i == `ADCSR_ADDR_RES_HIGH;
wire wr_low = sfr_we_i && sfr_addr_i == `ADCSR_ADDR_RES_LOW;

// -----------------------------------------------------------------
// helpers
// -----------------------------------------------------------------
function [4:0] repeat_total;
	input [1:0] code;
	begin
		case (code)
			2'h0: repeat_total = 5'h01;
			2'h1: repeat_total = 5'h04;
			2'h2: repeat_total = 5'h08;
			default: repeat_total = 5'h10;
		endcase
	end
endfunction

// -----------------------------------------------------------------
// start triggers
// -----------------------------------------------------------------
always @(posedge clk_sys_i) begin
	// the third stage only feeds the edge detector
	if (!rstn_i) begin
		pin_s1 <= 1'b0;
		pin_s2 <= 1'b0;
		pin_s3 <= 1'b0;
	end else begin
		pin_s1 <= external_convert_start_pin_i;
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
	end
end

// a control write may pick the mode and start in the same cycle
wire [1:0] mode_now = wr_control ? sfr_wdata_i[1:0] : start_source_select;
reg trigger;
always @* begin
	case (mode_now)
		`ADCSR_SRC_WRITE: trigger = wr_control &&
			sfr_wdata_i[`ADCSR_CN_BUSY];
		`ADCSR_SRC_TIMER1: trigger = timer1_ovf_i;
		`ADCSR_SRC_PIN: trigger = pin_s2 && !pin_s3;
		default: trigger = timer2_ovf_i;
	endcase
end

wire enabled = converter_control[`ADCSR_CN_ENABLE];
// enable written together with busy must not lose that start
wire start_ok = wr_control ? sfr_wdata_i[`ADCSR_CN_ENABLE] : enabled;
// burst keeps launching after one start until the count is reached
wire launch = start_ok && !sample_start_o &&
	((trigger && !busy) ||
	(burst_mode_enable && busy && sample_done_i &&
	next_done_count != repeat_total(repeat_count_field)));

// -----------------------------------------------------------------
// sar clock: source is system clock or burst oscillator
// -----------------------------------------------------------------
wire src_tick = burst_mode_enable ? burst_osc_tick_i : 1'b1;

// divider idles at zero while disabled, so the first tick is a full period
adcsr_clkdiv u_clkdiv (
	.clk_sys_i(clk_sys_i),
	.rstn_i(rstn_i),
	.run_i(enabled),
	.src_tick_i(src_tick),
	.divide_i(sar_clock_divide),
	.sar_tick_o(sar_tick_o)
);

// -----------------------------------------------------------------
// conversion sequencing and accumulation
// -----------------------------------------------------------------
always @* begin
	next_done_count = done_count + 5'h01;
end

wire last_sample = sample_done_i && busy &&
	next_done_count == repeat_total(repeat_count_field);
wire busy_fall = last_sample;

always @(posedge clk_sys_i) begin
	if (!rstn_i) begin
		busy <= 1'b0;
		done_count <= 5'h00;
		accum <= 16'h0000;
		sample_start_o <= 1'b0;
	end else begin
		sample_start_o <= launch;
		// an abort clears busy without raising the done flag
		if (!start_ok) begin
			busy <= 1'b0;
			done_count <= 5'h00;
		end else if (trigger && !busy) begin
			busy <= 1'b1;
			done_count <= 5'h00;
			accum <= 16'h0000;
		end else if (sample_done_i && busy) begin
			accum <= accum + {4'h0, sample_i};
			done_count <= next_done_count;
			// non-burst waits idle-busy for the next start
			if (last_sample) begin
				busy <= 1'b0;
			end
		end
		if (start_ok && busy && !burst_mode_enable && trigger &&
			!sample_start_o && !last_sample) begin
			sample_start_o <= 1'b1;
		end
	end
end

// -----------------------------------------------------------------
// control and config registers
// -----------------------------------------------------------------
always @(posedge clk_sys_i) begin
	if (!rstn_i) begin
		converter_config <= `ADCSR_RST_CONFIG;
		converter_control <= `ADCSR_RST_CONTROL;
		input_channel_field_o <= `ADCSR_RST_CHANNEL;
	end else begin
		if (sfr_we_i && sfr_addr_i == `ADCSR_ADDR_CONFIG) begin
			converter_config <= {sfr_wdata_i[7:1], sfr_wdata_i[0]};
		end
		if (sfr_we_i && sfr_addr_i == `ADCSR_ADDR_CHANNEL) begin
			input_channel_field_o <= sfr_wdata_i[4:0];
		end
		if (wr_control) begin
			converter_control[7:6] <= sfr_wdata_i[7:6];
			converter_control[2:0] <= sfr_wdata_i[2:0];
			converter_control[`ADCSR_CN_DONE] <= sfr_wdata_i[5];
			converter_control[`ADCSR_CN_WIN] <= sfr_wdata_i[3];
		end
		// set beats a same-cycle software clear
		if (busy_fall) begin
			converter_control[`ADCSR_CN_DONE] <= 1'b1;
		end
		if (window_match_i) begin
			converter_control[`ADCSR_CN_WIN] <= 1'b1;
		end
	end
end

// -----------------------------------------------------------------
// result bytes and indirect gain registers
// -----------------------------------------------------------------
always @(posedge clk_sys_i) begin
	if (!rstn_i) begin
		accum_o <= {`ADCSR_RST_RESULT, `ADCSR_RST_RESULT};
		gain_addr <= 8'h00;
		gain_word_o <= {`ADCSR_RST_GAIN_HIGH, `ADCSR_RST_GAIN_LOW};
		extra_sixtyfourth_gain_o <= `ADCSR_RST_GAIN_EXTRA;
		converter_enable_o <= 1'b0;
	end else begin
		// tracks the control bit, so it is high with any start it allows
		converter_enable_o <= start_ok;
		if (busy_fall) begin
			accum_o <= accum + {4'h0, sample_i};
		end else if (!gain_program_enable) begin
			if (wr_high) begin
				accum_o[15:8] <= sfr_wdata_i;
			end
			if (wr_low) begin
				accum_o[7:0] <= sfr_wdata_i;
			end
		end
		if (gain_program_enable && wr_high) begin
			gain_addr <= sfr_wdata_i;
		end
		// reserved gain bits are simply not stored
		if (gain_program_enable && wr_low) begin
			case (gain_addr)
				`ADCSR_GAIN_HIGH: gain_word_o[11:4] <= sfr_wdata_i;
				`ADCSR_GAIN_LOW: gain_word_o[3:0] <= sfr_wdata_i[7:4];
				`ADCSR_GAIN_EXTRA:
					extra_sixtyfourth_gain_o <= sfr_wdata_i[0];
				default: ;
			endcase
		end
	end
end

// -----------------------------------------------------------------
// read path; gain registers never appear here
// -----------------------------------------------------------------
reg [7:0] high_view;
reg [7:0] low_view;
always @* begin
	if (left_justify_select) begin
		high_view = accum_o[11:4];
		low_view = {accum_o[3:0], 4'h0};
	end else begin
		low_view = accum_o[7:0];
		// high byte keeps sum bits up to 11, 12, 13 or 15 for 1, 4, 8 or 16 samples; bits above read zero
		case (repeat_count_field)
			2'h0: high_view = {4'h0, accum_o[11:8]};
			2'h1: high_view = {3'h0, accum_o[12:8]};
			2'h2: high_view = {2'h0, accum_o[13:8]};
			default: high_view = accum_o[15:8];
		endcase
	end
end

always @(posedge clk_sys_i) begin
	if (!rstn_i) begin
		sfr_rdata_o <= 8'h00;
	end else if (sfr_re_i) begin
		case (sfr_addr_i)
			`ADCSR_ADDR_CONFIG: sfr_rdata_o <= converter_config;
			`ADCSR_ADDR_RES_LOW: sfr_rdata_o <= low_view;
			`ADCSR_ADDR_RES_HIGH: sfr_rdata_o <= high_view;
			`ADCSR_ADDR_CONTROL: sfr_rdata_o <= {converter_control[7:5],
				busy, converter_control[3:0]};
			`ADCSR_ADDR_CHANNEL: sfr_rdata_o <=
				{3'h0, input_channel_field_o};
			default: sfr_rdata_o <= 8'h00;
		endcase
	end
end

endmodule // adcsr_ctrl

// *** test/adcsr_ctrl_chk.sv ***
// checker: port-level properties of the adc control block
// assumes it is bound onto adcsr_ctrl, one clock domain
`timescale 1ns/1ps
module adcsr_ctrl_chk (
	// clock, reset and register bus
	input wire clk_sys_i,
	input wire rstn_i,
	input wire [7:0] sfr_addr_i,
	input wire [7:0] sfr_wdata_i,
	input wire sfr_we_i,
	input wire sfr_re_i,
	input wire [7:0] sfr_rdata_o,
	// analog core side
	input wire sample_done_i,
	input wire [11:0] sample_i,
	input wire sample_start_o,
	input wire converter_enable_o,
	input wire [11:0] gain_word_o,
	input wire extra_sixtyfourth_gain_o,
	input wire [15:0] accum_o
);
	reg gmode;
	reg lj;
	reg [1:0] rpt;
	reg [7:0] gaddr;
	wire cn_w = sfr_we_i && sfr_addr_i == 8'he8;
	wire gd_w = sfr_we_i && sfr_addr_i == 8'hbd && gmode;
	// ---------------------------------------------
	// shadow of the fields the properties hinge on
	// ---------------------------------------------
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			gmode <= 1'b0;
			lj <= 1'b0;
			rpt <= 2'h0;
			gaddr <= 8'h00;
		end else begin
			if (sfr_we_i && sfr_addr_i == 8'hbc) begin
				gmode <= sfr_wdata_i[0];
				rpt <= sfr_wdata_i[2:1];
			end
			if (cn_w)
				lj <= sfr_wdata_i[2];
			if (sfr_we_i && sfr_addr_i == 8'hbe && gmode)
				gaddr <= sfr_wdata_i;
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	property p_start;
		cn_w && sfr_wdata_i[7] && sfr_wdata_i[4] && sfr_wdata_i[1:0] == 2'h0
			&& !gmode |=> sample_start_o;
	endproperty
	a_start: assert property (p_start)
		else $error("busy write gave no start");
	property p_en; sample_start_o |-> converter_enable_o; endproperty
	a_en: assert property (p_en)
		else $error("start while disabled");
	property p_unmap;
		sfr_re_i && sfr_addr_i inside {8'h04, 8'h07, 8'h08} |=> !sfr_rdata_o;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("gain address readable");
	property p_rst;
		$rose(rstn_i) |-> !accum_o && !gain_word_o && extra_sixtyfourth_gain_o;
	endproperty
	a_rst: assert property (p_rst)
		else $error("bad reset state");
	property p_gh;
		gd_w && gaddr == 8'h04 |=> gain_word_o[11:4] == $past(sfr_wdata_i);
	endproperty
	a_gh: assert property (p_gh)
		else $error("gain high not loaded");
	property p_gl;
		gd_w && gaddr == 8'h07 |=> gain_word_o[3:0] == $past(sfr_wdata_i[7:4]);
	endproperty
	a_gl: assert property (p_gl)
		else $error("gain low not loaded");
	property p_gx;
		gd_w && gaddr == 8'h08
			|=> extra_sixtyfourth_gain_o == $past(sfr_wdata_i[0]);
	endproperty
	a_gx: assert property (p_gx)
		else $error("extra gain not loaded");
	property p_gkeep; !gd_w |=> $stable(gain_word_o); endproperty
	a_gkeep: assert property (p_gkeep)
		else $error("gain word moved");
	property p_acc;
		sample_done_i && rpt == 2'h0 && !lj
			|=> accum_o == {4'h0, $past(sample_i)};
	endproperty
	a_acc: assert property (p_acc)
		else $error("single result wrong");
	c_start: cover property (p_start);
	c_gh: cover property (gd_w && gaddr == 8'h04);
	c_acc: cover property (sample_done_i && rpt == 2'h3);
endmodule // adcsr_ctrl_chk

// *** test/adcsr_core_model.sv ***
// model of the analog sar core: one sample per start pulse
// assumes start pulses are one cycle on clk_sys_i
`timescale 1ns/1ps
module adcsr_core_model (
	// clock
	input wire clk_sys_i,
	// converter side
	input wire start_i,
	input wire [3:0] dly_i,
	input wire [11:0] value_i,
	output reg done_o = 1'b0,
	output reg [11:0] sample_o = 12'h000
);
	integer cnt = -1;
	// sample is only valid with done; it churns otherwise
	always @(posedge clk_sys_i) begin
		done_o <= (cnt == 0);
		sample_o <= (cnt == 0) ? value_i : ~sample_o;
		if (start_i)
			cnt <= dly_i;
		else if (cnt >= 0)
			cnt <= cnt - 1;
	end
endmodule // adcsr_core_model

// *** test/adc_sar_control_registers_tb_top.sv ***
// testbench for the adc control block with core model
// assumes the checker is bound below
`timescale 1ns/1ps
module adc_sar_control_registers_tb_top;
	reg clk_sys_i = 1'b0;
	reg rstn_i = 1'b0;
	reg [7:0] sfr_addr_i = 8'h00;
	reg [7:0] sfr_wdata_i = 8'h00;
	reg sfr_we_i = 1'b0;
	reg sfr_re_i = 1'b0;
	reg timer1_ovf_i = 1'b0;
	reg timer2_ovf_i = 1'b0;
	reg external_convert_start_pin_i = 1'b0;
	reg burst_osc_tick_i = 1'b0;
	reg window_match_i = 1'b0;
	reg [11:0] sample_value = 12'h000;
	reg [3:0] core_delay = 4'h2;
	wire sample_done_i, sample_start_o, sar_tick_o, converter_enable_o;
	wire extra_sixtyfourth_gain_o;
	wire [11:0] sample_i, gain_word_o;
	wire [7:0] sfr_rdata_o;
	wire [4:0] input_channel_field_o;
	wire [15:0] accum_o;
	integer failures = 0;
	integer samples_checked = 0;
	integer i, j;
	reg [7:0] d, cfg, ctl;
	reg [3:0] nt, kind;
	reg [15:0] ex;
	reg [51:0] rows [0:4];
	adcsr_ctrl dut (.clk_sys_i, .rstn_i, .sfr_addr_i, .sfr_wdata_i,
		.sfr_we_i, .sfr_re_i, .sfr_rdata_o, .timer1_ovf_i, .timer2_ovf_i,
		.external_convert_start_pin_i, .burst_osc_tick_i, .sample_done_i,
		.sample_i, .window_match_i, .sample_start_o, .sar_tick_o,
		.converter_enable_o, .input_channel_field_o, .gain_word_o,
		.extra_sixtyfourth_gain_o, .accum_o);
	adcsr_core_model core (.clk_sys_i, .start_i(sample_start_o),
		.dly_i(core_delay), .value_i(sample_value), .done_o(sample_done_i),
		.sample_o(sample_i));
	initial forever #4 clk_sys_i = ~clk_sys_i;
	always @(negedge clk_sys_i) burst_osc_tick_i <= ~burst_osc_tick_i;
	initial begin
		#200000;
		failures = failures + 1;
		close_out;
	end
	// ---------------------------------------------
	// bus, start pulse, tick count, compare and closing tasks
	// ---------------------------------------------
	task chk(input [95:0] nm, input [15:0] e, input [15:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("CHECK FAILED %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] v);
		begin
			sfr_addr_i = a;
			sfr_wdata_i = v;
			sfr_we_i = 1'b1;
			@(negedge clk_sys_i);
			sfr_we_i = 1'b0;
			@(negedge clk_sys_i);
		end
	endtask
	task rd(input [7:0] a, output [7:0] v);
		begin
			sfr_addr_i = a;
			sfr_re_i = 1'b1;
			@(negedge clk_sys_i);
			sfr_re_i = 1'b0;
			@(negedge clk_sys_i);
			v = sfr_rdata_o;
		end
	endtask
	task rc(input [7:0] a, input [7:0] e);
		reg [7:0] v;
		begin
			rd(a, v);
			chk("sfr_rdata_o", {8'h00, e}, {8'h00, v});
		end
	endtask
	task pl(input [1:0] k);
		begin
			{timer2_ovf_i, external_convert_start_pin_i, timer1_ovf_i} =
				3'h1 << (k - 1);
			@(negedge clk_sys_i);
			{timer2_ovf_i, external_convert_start_pin_i, timer1_ovf_i} = 3'h0;
			repeat (12) @(negedge clk_sys_i);
		end
	endtask
	task tk(input [15:0] e);
		reg [15:0] n;
		begin
			n = 16'h0;
			repeat (40) begin
				@(negedge clk_sys_i);
				n = n + (sar_tick_o === 1'b1);
			end
			chk("sar ticks", e, n);
		end
	endtask
	task close_out;
		begin
			$display("checked %0d failures %0d", samples_checked, failures);
			if (failures == 0 && samples_checked > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		// left justify only with single conversions
		rows[0] = {8'hf8, 8'h90, 4'h0, 4'h0, 12'habc, 16'h0abc};
		rows[1] = {8'hf8, 8'h94, 4'h0, 4'h0, 12'habc, 16'habc0};
		rows[2] = {8'hfa, 8'h81, 4'h4, 4'h1, 12'h123, 16'h048c};
		rows[3] = {8'hfc, 8'hc2, 4'h1, 4'h2, 12'hfff, 16'h3ff8};
		rows[4] = {8'hfe, 8'hc3, 4'h1, 4'h3, 12'hfff, 16'hfff0};
		repeat (2) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		for (i = 0; i < 5; i = i + 1) begin
			{cfg, ctl, nt, kind, sample_value, ex} = rows[i];
			core_delay = i[3:0] + 4'h1;
			wr(8'hbc, cfg);
			wr(8'he8, ctl);
			repeat (nt) pl(kind[1:0]);
			d = 8'h00;
			for (j = 0; j < 100 && !d[5]; j = j + 1)
				rd(8'he8, d);
			chk("done flag", {8'h0, ctl & 8'hef | 8'h20}, {8'h0, d});
			rc(8'hbe, ex[15:8]);
			rc(8'hbd, ex[7:0]);
			wr(8'he8, 8'h00);
		end
		// no conversion while programming gain
		wr(8'hbc, 8'hf9);
		wr(8'hbe, 8'h04);
		wr(8'hbd, 8'h6c);
		wr(8'hbe, 8'h07);
		wr(8'hbd, 8'ha0);
		wr(8'hbe, 8'h08);
		wr(8'hbd, 8'h00);
		chk("gain_word_o", 16'h06ca, {4'h0, gain_word_o});
		chk("extra gain", 16'h0, {15'h0, extra_sixtyfourth_gain_o});
		rc(8'h04, 8'h00);
		wr(8'hbb, 8'hf9);
		rc(8'hbb, 8'h19);
		chk("channel", 16'h0019, {11'h0, input_channel_field_o});
		window_match_i = 1'b1;
		@(negedge clk_sys_i);
		window_match_i = 1'b0;
		rc(8'he8, 8'h08);
		rc(8'he8, 8'h08);
		wr(8'he8, 8'h00);
		rc(8'he8, 8'h00);
		wr(8'hbc, 8'h18);
		wr(8'he8, 8'h80);
		chk("enable", 16'h1, {15'h0, converter_enable_o});
		tk(16'd10);
		wr(8'he8, 8'hc0);
		tk(16'd5);
		rstn_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		chk("extra gain", 16'h1, {15'h0, extra_sixtyfourth_gain_o});
		chk("gain_word_o", 16'h0, {4'h0, gain_word_o});
		rc(8'hbc, 8'hf8);
		rc(8'he8, 8'h00);
		rc(8'hbe, 8'h00);
		rc(8'hbd, 8'h00);
		close_out;
	end
endmodule // adc_sar_control_registers_tb_top
bind adcsr_ctrl adcsr_ctrl_chk u_chk (.clk_sys_i, .rstn_i, .sfr_addr_i,
	.sfr_wdata_i, .sfr_we_i, .sfr_re_i, .sfr_rdata_o, .sample_done_i,
	.sample_i, .sample_start_o, .converter_enable_o, .gain_word_o,
	.extra_sixtyfourth_gain_o, .accum_o);
